// ===== hdl/etc_defs.svh
// constants for the edge triggered up/down event counter
`ifndef ETC_DEFS_SVH
`define ETC_DEFS_SVH

// ----------------------------------------------------------------
// count limits and reset values
// ----------------------------------------------------------------
`define ETC_CNT_W 32
`define ETC_CNT_MAX 32'h7fffffff
`define ETC_CNT_MIN 32'h80000000
`define ETC_CNT_RST 32'h00000000
`define ETC_TGT_RST 32'h00000000
`define ETC_STEP 32'h00000001

`endif

// ===== hdl/etc_pkg.sv
// types shared by the event counter modules
`include "etc_defs.svh"
package etc_pkg;
   // signed running count and target
   typedef logic signed [`ETC_CNT_W-1:0] etc_count_t;
   // scan phase: init means the next executed scan is a first scan
   typedef enum logic {ETC_INIT, ETC_RUN} etc_phase_t;
endpackage : etc_pkg

// ===== hdl/etc_step_if.sv
// carrier between the counter core and its step unit
`timescale 1ns/1ns
interface etc_step_if;
   etc_pkg::etc_count_t cur;
   logic inc;
   logic dec;
   etc_pkg::etc_count_t nxt;
   logic ovf;
   logic unf;
   modport core (output cur, output inc, output dec, input nxt, input ovf, input unf);
   modport unit (input cur, input inc, input dec, output nxt, output ovf, output unf);
endinterface : etc_step_if

// ===== hdl/etc_step.sv
// step unit: increment then decrement with wrap detection
`timescale 1ns/1ns
`include "etc_defs.svh"
module etc_step (
   etc_step_if.unit s
);
   // ----------------------------------------------------------------
   // increment first, then decrement on the intermediate value
   // ----------------------------------------------------------------
   etc_pkg::etc_count_t mid;
   always_comb begin
      mid = s.cur;
      s.ovf = 1'b0;
      s.unf = 1'b0;
      if (s.inc) begin
         if (s.cur == `ETC_CNT_MAX) begin
            s.ovf = 1'b1;
         end
         mid = s.cur + `ETC_STEP; // max rolls to min naturally
      end
      s.nxt = mid;
      // the decrement sees the already incremented value
      if (s.dec) begin
         if (mid == `ETC_CNT_MIN) begin
            s.unf = 1'b1;
         end
         s.nxt = mid - `ETC_STEP; // min rolls to max naturally
      end
   end
endmodule : etc_step

// ===== hdl/etc_counter.sv
// edge triggered up-only / bidirectional event counter core
//
// Operation
// - up-only: line input true with edge memory false adds one.
// - up-only: line input false clears the up edge memory.
// - edge memory holds the evaluated input, so only rising edges count.
// - initialisation pass sets edge memory true, suppressing first-scan count.
// - up-only line output mirrors line input on every evaluation.
// - target flag set while signed count is at least the target.
// - counting continues past the target; flag stays set.
// - increment past maximum sets upper wrap flag, count goes most negative.
// - decrement past minimum sets lower wrap flag, count goes maximum.
// - bidirectional: rising edge of up pulse input adds one.
// - bidirectional: rising edge of down pulse input subtracts one.
// - bidirectional: execute clear: count and flags unchanged, result valid cleared; execute defaults set.
// - bidirectional reset input set resets the counter; defaults cleared.
// - result valid output and both edge memories are driven out.
// - simultaneous up and down edges: increment first, then decrement.
// - disabled counter keeps its count, even on a reset request; bidirectional reset needs execute set.
// - first scan, or execute false in bidirectional mode, primes edge memories against held inputs.
// - counter reset clears count to zero, the three flags and both edge memories, and sets result valid.
`timescale 1ns/1ns
`include "etc_defs.svh"
module etc_counter (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic eval_strobe,
   input wire logic init_pass,
   input wire logic mode_bidir,
   input wire logic line_cond_in,
   input wire logic execute_input,
   input wire logic up_pulse_input,
   input wire logic down_pulse_input,
   input wire logic counter_reset,
   input wire etc_pkg::etc_count_t target_count,
   output logic line_cond_out,
   output etc_pkg::etc_count_t running_count,
   output logic target_reached_flag,
   output logic upper_wrap_flag,
   output logic lower_wrap_flag,
   output logic up_edge_memory,
   output logic down_edge_memory,
   output logic result_valid_output
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   etc_pkg::etc_phase_t phase_ff, nxt_phase;
   etc_pkg::etc_count_t count_ff, nxt_count;
   etc_pkg::etc_count_t target_ff, nxt_target;
   logic line_out_ff, nxt_line_out;
   logic reached_ff, nxt_reached;
   logic upper_ff, nxt_upper;
   logic lower_ff, nxt_lower;
   logic up_mem_ff, nxt_up_mem;
   logic dn_mem_ff, nxt_dn_mem;
   logic valid_ff, nxt_valid;

   // decoded scan conditions
   logic executes;
   logic do_reset;
   logic up_edge;
   logic dn_edge;

   etc_step_if step_bus ();

   etc_step u_step (
      .s (step_bus)
   );

   // ----------------------------------------------------------------
   // edge detection and step requests
   // ----------------------------------------------------------------
   // the up-only flavour ignores execute; bidirectional needs it set
   assign executes = eval_strobe & ~init_pass & (~mode_bidir | execute_input);
   assign do_reset = executes & counter_reset;
   // edges are blanked on the first executed scan after initialisation,
   // so an input already high when the program starts is not counted
   assign up_edge = (phase_ff == etc_pkg::ETC_RUN) & ~up_mem_ff &
                    (mode_bidir ? up_pulse_input : line_cond_in);
   assign dn_edge = (phase_ff == etc_pkg::ETC_RUN) & mode_bidir &
                    down_pulse_input & ~dn_mem_ff;
   assign step_bus.cur = count_ff;
   assign step_bus.inc = up_edge;
   assign step_bus.dec = dn_edge;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_phase = phase_ff;
      nxt_count = count_ff;
      nxt_target = target_ff;
      nxt_line_out = line_out_ff;
      nxt_reached = reached_ff;
      nxt_upper = upper_ff;
      nxt_lower = lower_ff;
      nxt_up_mem = up_mem_ff;
      nxt_dn_mem = dn_mem_ff;
      nxt_valid = valid_ff;
      if (init_pass) begin
         // initialisation pass: arm memories high, no result yet
         nxt_phase = etc_pkg::ETC_INIT;
         nxt_up_mem = 1'b1;
         nxt_dn_mem = 1'b1;
         nxt_valid = 1'b0;
      end else if (eval_strobe) begin
         nxt_line_out = line_cond_in;
         if (!executes) begin
            // disabled: count and flags hold, memories primed high
            nxt_up_mem = 1'b1;
            nxt_dn_mem = 1'b1;
            nxt_valid = 1'b0;
         end else if (do_reset) begin
            nxt_phase = etc_pkg::ETC_RUN;
            nxt_count = `ETC_CNT_RST;
            nxt_target = target_count;
            nxt_reached = 1'b0;
            nxt_upper = 1'b0;
            nxt_lower = 1'b0;
            nxt_up_mem = 1'b0;
            nxt_dn_mem = 1'b0;
            nxt_valid = 1'b1;
         end else begin
            nxt_phase = etc_pkg::ETC_RUN;
            nxt_count = step_bus.nxt;
            nxt_target = target_count;
            nxt_upper = upper_ff | step_bus.ovf; // sticky
            nxt_lower = lower_ff | step_bus.unf; // sticky
            // compare the new count against the new target, signed
            nxt_reached = (step_bus.nxt >= target_count);
            if (mode_bidir) begin
               nxt_up_mem = up_pulse_input;
               nxt_dn_mem = down_pulse_input;
            end else begin
               nxt_up_mem = line_cond_in;
            end
            nxt_valid = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // memories come up high so the first scan cannot count a held input
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         phase_ff <= etc_pkg::ETC_INIT;
         count_ff <= `ETC_CNT_RST;
         target_ff <= `ETC_TGT_RST;
         line_out_ff <= 1'b0;
         reached_ff <= 1'b0;
         upper_ff <= 1'b0;
         lower_ff <= 1'b0;
         up_mem_ff <= 1'b1;
         dn_mem_ff <= 1'b1;
         valid_ff <= 1'b0;
      end else begin
         phase_ff <= nxt_phase;
         count_ff <= nxt_count;
         target_ff <= nxt_target;
         line_out_ff <= nxt_line_out;
         reached_ff <= nxt_reached;
         upper_ff <= nxt_upper;
         lower_ff <= nxt_lower;
         up_mem_ff <= nxt_up_mem;
         dn_mem_ff <= nxt_dn_mem;
         valid_ff <= nxt_valid;
      end
   end

   // ----------------------------------------------------------------
   // outputs, each straight from a flip-flop
   // ----------------------------------------------------------------
   assign line_cond_out = line_out_ff;
   assign running_count = count_ff;
   assign target_reached_flag = reached_ff;
   assign upper_wrap_flag = upper_ff;
   assign lower_wrap_flag = lower_ff;
   assign up_edge_memory = up_mem_ff;
   assign down_edge_memory = dn_mem_ff;
   assign result_valid_output = valid_ff;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   // one ordinary executed scan, no reset
   sequence s_count_scan;
      executes && !counter_reset;
   endsequence

   // an executed scan that carries a reset request
   sequence s_reset_scan;
      executes && counter_reset;
   endsequence

   up_edge_count_a: assert property (
      (s_count_scan and (!mode_bidir && up_edge))
      |=> count_ff == etc_pkg::etc_count_t'($past(count_ff) + `ETC_STEP))
      else $error("up-only edge did not add one");

   mem_follow_a: assert property (
      (s_count_scan and !mode_bidir) |=> up_mem_ff == $past(line_cond_in))
      else $error("up edge memory does not hold evaluated input");

   mem_clear_a: assert property (
      (eval_strobe && !init_pass && !mode_bidir && !line_cond_in)
      ##1 (!eval_strobe && !init_pass)[*2] |-> !up_mem_ff)
      else $error("false line input left edge memory set");

   init_prime_a: assert property (
      init_pass |=> up_mem_ff && dn_mem_ff && !valid_ff && phase_ff == etc_pkg::ETC_INIT)
      else $error("initialisation pass did not arm edge memories");

   first_scan_a: assert property (
      (s_count_scan and (phase_ff == etc_pkg::ETC_INIT)) |=> $stable(count_ff))
      else $error("first scan changed the count");

   line_mirror_a: assert property (
      (eval_strobe && !init_pass) |=> line_cond_out == $past(line_cond_in))
      else $error("line output does not mirror line input");

   target_flag_a: assert property (
      s_count_scan |=> target_reached_flag == (running_count >= target_ff))
      else $error("target flag disagrees with signed compare");

   upper_wrap_a: assert property (
      (s_count_scan and (up_edge && !dn_edge && count_ff == `ETC_CNT_MAX))
      |=> upper_wrap_flag && running_count == `ETC_CNT_MIN)
      else $error("overflow did not wrap to minimum with flag");

   lower_wrap_a: assert property (
      (s_count_scan and (dn_edge && !up_edge && count_ff == `ETC_CNT_MIN))
      |=> lower_wrap_flag && running_count == `ETC_CNT_MAX)
      else $error("underflow did not wrap to maximum with flag");

   down_edge_count_a: assert property (
      (s_count_scan and (dn_edge && !up_edge))
      |=> count_ff == etc_pkg::etc_count_t'($past(count_ff) - `ETC_STEP))
      else $error("down edge did not subtract one");

   both_edges_a: assert property (
      (s_count_scan and (up_edge && dn_edge)) |=> $stable(count_ff))
      else $error("simultaneous edges did not cancel");

   hold_disabled_a: assert property (
      (eval_strobe && !init_pass && mode_bidir && !execute_input)
      |=> $stable(count_ff) && $stable(reached_ff) && !valid_ff && up_mem_ff)
      else $error("disabled scan changed outputs");

   reset_clear_a: assert property (
      s_reset_scan |=> running_count == `ETC_CNT_RST && !target_reached_flag
      && !upper_wrap_flag && !lower_wrap_flag && !up_mem_ff && !dn_mem_ff)
      else $error("counter reset left state behind");

   wrap_sticky_a: assert property (
      (upper_ff && !init_pass) ##0 (!do_reset)[*3] |=> upper_ff)
      else $error("upper wrap flag dropped without reset");

   idle_hold_a: assert property (
      (!eval_strobe && !init_pass) |=> $stable(count_ff) && $stable(valid_ff))
      else $error("state moved without an evaluation");

   // scan bookkeeping: bidirectional steps, capture of target and memories
   up_edge_bidir_a: assert property (
      (s_count_scan and (mode_bidir && up_edge && !dn_edge))
      |=> count_ff == etc_pkg::etc_count_t'($past(count_ff) + `ETC_STEP))
      else $error("bidirectional up edge did not add one");

   bidir_mem_follow_a: assert property (
      (s_count_scan and mode_bidir)
      |=> up_mem_ff == $past(up_pulse_input) && dn_mem_ff == $past(down_pulse_input))
      else $error("pulse edge memories do not hold evaluated inputs");

   valid_after_scan_a: assert property (
      (s_count_scan or s_reset_scan)
      |=> result_valid_output)
      else $error("executed scan did not flag a valid result");

   target_load_a: assert property (
      (s_count_scan or s_reset_scan)
      |=> target_ff == $past(target_count))
      else $error("executed scan did not load the target");

   keep_counting_a: assert property (
      (s_count_scan and (target_reached_flag && up_edge && !mode_bidir
      && target_count == target_ff && count_ff != `ETC_CNT_MAX)) |=> target_reached_flag)
      else $error("counting past the target dropped the flag");

   bidir_reset_a: assert property (
      (s_reset_scan and mode_bidir)
      |=> running_count == `ETC_CNT_RST && result_valid_output)
      else $error("bidirectional reset request did not clear the count");

endmodule : etc_counter

// ===== bench/etc_scan_host.sv
// scan driver model: turns each scan request into one evaluation strobe
`timescale 1ns/1ns
module etc_scan_host (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic req,
   input wire logic [3:0] gap,
   output logic eval_strobe,
   output logic done
);
   logic busy_ff;
   logic [3:0] wait_ff;
   // ------------------------------------------------------------
   // scan pacing
   // ------------------------------------------------------------
   // a random idle gap mimics program scans of varying length
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         busy_ff <= 1'b0;
         wait_ff <= 4'h0;
         eval_strobe <= 1'b0;
         done <= 1'b0;
      end else begin
         eval_strobe <= 1'b0;
         done <= eval_strobe; // outputs have landed one edge after the strobe
         if (req && !busy_ff) begin
            busy_ff <= 1'b1;
            wait_ff <= gap;
         end else if (busy_ff && wait_ff == 4'h0) begin
            eval_strobe <= 1'b1; // single-cycle strobe per scan
            busy_ff <= 1'b0;
         end else if (busy_ff) begin
            wait_ff <= wait_ff - 4'h1;
         end
      end
   end
endmodule : etc_scan_host

// ===== bench/tb_etc_counter.sv
// self-checking bench for the event counter core
`timescale 1ns/1ns
module tb_etc_counter;
   logic core_clk, nrst, eval_strobe, init_pass, mode_bidir, line_cond_in, execute_input;
   logic up_pulse_input, down_pulse_input, counter_reset, req, done;
   logic [3:0] gap;
   etc_pkg::etc_count_t target_count, running_count, m_cnt, m_tgt, tg;
   logic line_cond_out, target_reached_flag, upper_wrap_flag, lower_wrap_flag;
   logic up_edge_memory, down_edge_memory, result_valid_output;
   logic m_rch, m_ovf, m_unf, m_upm, m_dnm, m_lo, m_val;
   int mismatches, total_checks, i;
   etc_counter DUT (.core_clk(core_clk), .nrst(nrst), .eval_strobe(eval_strobe),
      .init_pass(init_pass), .mode_bidir(mode_bidir), .line_cond_in(line_cond_in),
      .execute_input(execute_input), .up_pulse_input(up_pulse_input),
      .down_pulse_input(down_pulse_input), .counter_reset(counter_reset),
      .target_count(target_count), .line_cond_out(line_cond_out),
      .running_count(running_count), .target_reached_flag(target_reached_flag),
      .upper_wrap_flag(upper_wrap_flag), .lower_wrap_flag(lower_wrap_flag),
      .up_edge_memory(up_edge_memory), .down_edge_memory(down_edge_memory),
      .result_valid_output(result_valid_output));
   etc_scan_host host (.core_clk(core_clk), .nrst(nrst), .req(req), .gap(gap),
      .eval_strobe(eval_strobe), .done(done));
   // ------------------------------------------------------------
   // clock and reporting
   // ------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, nm, got, exp);
      end
   endtask : chk
   task results;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results
   // ------------------------------------------------------------
   // reference model
   // ------------------------------------------------------------
   // one executed or refused scan, worked out from the counting rules
   function automatic void model_scan(input logic md, lc, ex, up, dn, rs, input etc_pkg::etc_count_t t);
      logic ie;
      logic de;
      m_lo = lc;
      if (md && !ex) begin
         m_upm = 1'b1;
         m_dnm = 1'b1;
         m_val = 1'b0;
      end else if (rs) begin
         {m_cnt, m_rch, m_ovf, m_unf, m_upm, m_dnm} = '0;
         m_tgt = t;
         m_val = 1'b1;
      end else begin
         ie = (md ? up : lc) && !m_upm;
         de = md && dn && !m_dnm;
         if (ie && m_cnt == 32'sh7fffffff) m_ovf = 1'b1;
         if (ie) m_cnt = m_cnt + 32'sh1;
         if (de && m_cnt == 32'sh80000000) m_unf = 1'b1;
         if (de) m_cnt = m_cnt - 32'sh1;
         m_upm = md ? up : lc;
         if (md) m_dnm = dn;
         m_tgt = t;
         m_rch = m_cnt >= m_tgt;
         m_val = 1'b1;
      end
   endfunction : model_scan
   task automatic cmp_all(input logic md);
      chk("count", running_count, m_cnt);
      chk("reached", 32'(target_reached_flag), 32'(m_rch));
      chk("upper wrap", 32'(upper_wrap_flag), 32'(m_ovf));
      chk("lower wrap", 32'(lower_wrap_flag), 32'(m_unf));
      chk("line out", 32'(line_cond_out), 32'(m_lo));
      chk("up memory", 32'(up_edge_memory), 32'(m_upm));
      chk("valid", 32'(result_valid_output), 32'(m_val));
      if (md) chk("down memory", 32'(down_edge_memory), 32'(m_dnm));
   endtask : cmp_all
   // ------------------------------------------------------------
   // stimulus tasks
   // ------------------------------------------------------------
   // inputs are held until the host reports the scan done, so they stay stable
   task automatic scan(input logic md, lc, ex, up, dn, rs, input etc_pkg::etc_count_t t);
      int n;
      mode_bidir = md;
      line_cond_in = lc;
      execute_input = ex;
      up_pulse_input = up;
      down_pulse_input = dn;
      counter_reset = rs;
      target_count = t;
      gap = 4'($urandom_range(0, 5));
      req = 1'b1;
      @(posedge core_clk);
      #2 req = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 40) begin
         @(posedge core_clk);
         #2 n++;
      end
      if (n >= 40) begin
         mismatches++;
         $display("CHECK FAILED at %0t: scan never completed", $time);
         results();
      end
      model_scan(md, lc, ex, up, dn, rs, t);
      cmp_all(md);
   endtask : scan
   task automatic prescan(input logic md);
      init_pass = 1'b1;
      @(posedge core_clk);
      #2 init_pass = 1'b0;
      m_upm = 1'b1;
      m_dnm = 1'b1;
      m_val = 1'b0;
      @(posedge core_clk);
      #2 cmp_all(md);
   endtask : prescan
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {nrst, init_pass, mode_bidir, line_cond_in, up_pulse_input, down_pulse_input} = '0;
      {counter_reset, req, gap, execute_input} = '0;
      target_count = '0;
      mismatches = 0;
      total_checks = 0;
      void'($urandom(32'hfda68c46));
      repeat (8) @(posedge core_clk);
      #2 nrst = 1'b1;
      {m_cnt, m_tgt, m_rch, m_ovf, m_unf, m_lo, m_val} = '0;
      m_upm = 1'b1;
      m_dnm = 1'b1;
      cmp_all(1'b1);
      $display("test reset values done");
      scan(0, 1, 0, 0, 0, 0, 32'sd3); // held-high line gives no first-scan count
      for (i = 0; i < 12; i++) scan(0, i[0], 0, 0, 0, 0, 32'sd3);
      scan(0, 1, 1, 0, 0, 1, 32'sd3);
      scan(0, 1, 1, 0, 0, 0, -32'sd5);
      prescan(0);
      scan(0, 1, 1, 0, 0, 0, 32'sd0);
      $display("test up-only counting done");
      prescan(1);
      scan(1, 0, 1, 1, 1, 0, 32'sd0);
      scan(1, 0, 1, 0, 0, 0, 32'sd0);
      scan(1, 0, 1, 1, 1, 0, 32'sd0);
      scan(1, 0, 1, 0, 0, 0, 32'sd0);
      scan(1, 1, 0, 0, 0, 0, 32'sd9);
      scan(1, 0, 1, 1, 0, 0, 32'sd0);
      scan(1, 0, 1, 1, 1, 1, 32'sd0);
      $display("test bidirectional corners done");
      for (i = 0; i < 400; i++) begin
         tg = ($urandom_range(0, 3) == 0) ? $urandom : $signed(32'($urandom_range(0, 16))) - 32'sd8;
         scan(1, 1'($urandom), ($urandom_range(0, 7) != 0), 1'($urandom), 1'($urandom),
            ($urandom_range(0, 15) == 0), tg);
      end
      $display("test bidirectional random done");
      results();
   end
endmodule : tb_etc_counter
